// File: pfs_top.sv
`default_nettype none

module pfs_top (
  input  wire logic                     i_clock,         // 20 MHz clock
  input  wire logic                     i_reset_n,       // Sync reset, low
  input  wire logic                     i_rom_off_ext32, // Boot strap A
  input  wire logic                     i_rom_off_ext,   // Boot strap B/C
  input  wire logic [pfs_pkg::ADDR_W-1:0] i_addr,        // Byte address
  input  wire logic [pfs_pkg::DATA_W-1:0] i_wdata,       // Write data
  input  wire logic                     i_wr,            // Write strobe
  input  wire logic                     i_rd,            // Read strobe
  output logic      [pfs_pkg::DATA_W-1:0] o_rdata,       // Read data
  input  wire pfs_pkg::pfs_pin_s        i_port_a11,      // Port drive A11
  input  wire pfs_pkg::pfs_pin_s        i_port_b7,       // Port drive B7
  input  wire pfs_pkg::pfs_pin_s        i_port_c13,      // Port drive C13
  input  wire logic                     i_top_byte_strobe_mask_hold, // Bus ctl
  input  wire logic                     i_address_bit_nineteen_out,  // Bus ctl
  input  wire logic                     i_bus_request_out,           // Bus ctl
  input  wire logic                     i_address_bit_thirteen_out,  // Bus ctl
  input  wire pfs_pkg::pfs_pin_s        i_output_disable_pin_four,   // Drive
  input  wire logic                     i_serial0_transmit_out,      // Serial
  input  wire logic                     i_port_b_line_seven_in,      // Pin in
  output wire pfs_pkg::pfs_pin_s        o_port_a_line_eleven,        // Pin
  output wire pfs_pkg::pfs_pin_s        o_port_b_line_seven,         // Pin
  output wire pfs_pkg::pfs_pin_s        o_port_c_line_thirteen,      // Pin
  output wire logic                     o_external_interrupt_six,    // To irq
  output wire logic                     o_output_disable_pin_four_in // To poe
);
  import pfs_pkg::*;

  localparam logic [PIN_N-1:0][CODE_N-1:0] PIN_LEGAL =
    {LEGAL_C13, LEGAL_B7, LEGAL_A11};

  logic [DATA_W-1:0] port_a_low_function_select_3;
  logic [DATA_W-1:0] port_b_low_function_select_2;
  logic [DATA_W-1:0] port_c_function_select;
  logic [DATA_W-1:0] next_rdata;

  wire hit_a;
  wire hit_b;
  wire hit_c;
  wire wr_a;
  wire wr_b;
  wire wr_c;
  pfs_mode_t port_a_line11_function;
  pfs_mode_t port_b_line7_function;
  pfs_mode_t port_c_line13_function;
  pfs_pin_s  bus_drive_a11;
  pfs_pin_s  bus_drive_b7_adr;
  pfs_pin_s  bus_drive_b7_req;
  pfs_pin_s  bus_drive_c13;
  pfs_pin_s  serial_drive_b7;
  pfs_pin_s  input_only;

  pfs_mode_t                        pin_mode [PIN_N];
  pfs_pin_s                         pin_port [PIN_N];
  pfs_pin_s  [PIN_N-1:0][CODE_N-1:0] pin_fn;
  pfs_pin_s  [PIN_N-1:0]            pin_drive;

  // Address decode
  assign hit_a = (i_addr == OFS_PORT_A);
  assign hit_b = (i_addr == OFS_PORT_B);
  assign hit_c = (i_addr == OFS_PORT_C);
  assign wr_a  = i_wr & hit_a;
  assign wr_b  = i_wr & hit_b;
  assign wr_c  = i_wr & hit_c;

  // Port A register; reserved bits never stored
  // port A
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      port_a_low_function_select_3 <= i_rom_off_ext32 ? RST_EXT_PORT_A : RST_PORT_A;
    end else if (wr_a) begin
      port_a_low_function_select_3 <= i_wdata & MASK_PORT_A;
    end
  end

  // Port B register; low byte is read-only zero
  // port B
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      port_b_low_function_select_2 <= i_rom_off_ext ? RST_EXT_PORT_B : RST_PORT_B;
    end else if (wr_b) begin
      port_b_low_function_select_2 <= i_wdata & MASK_PORT_B;
    end
  end

  // Port C register holds only the line 13 field
  // port C
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      port_c_function_select <= i_rom_off_ext ? RST_EXT_PORT_C : RST_PORT_C;
    end else if (wr_c) begin
      port_c_function_select <= i_wdata & MASK_PORT_C;
    end
  end

  // Read select; unmapped addresses read zero
  // reserved zero
  assign next_rdata = hit_a ? port_a_low_function_select_3 :
                      hit_b ? port_b_low_function_select_2 :
                      hit_c ? port_c_function_select : '0;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      o_rdata <= '0;
    end else begin
      o_rdata <= i_rd ? next_rdata : '0;
    end
  end

  // Mode fields come straight from flops, so routing never glitches
  // registered routing
  assign port_a_line11_function = port_a_low_function_select_3[LSB_A11 +: MODE_W];
  assign port_b_line7_function  = port_b_low_function_select_2[LSB_B7 +: MODE_W];
  assign port_c_line13_function = port_c_function_select[LSB_C13 +: MODE_W];

  // Function sources seen as pin drives
  assign bus_drive_a11    = '{out: i_top_byte_strobe_mask_hold, oe: 1'b1};
  assign bus_drive_b7_adr = '{out: i_address_bit_nineteen_out, oe: 1'b1};
  assign bus_drive_b7_req = '{out: i_bus_request_out, oe: 1'b1};
  assign bus_drive_c13    = '{out: i_address_bit_thirteen_out, oe: 1'b1};
  assign serial_drive_b7  = '{out: i_serial0_transmit_out, oe: 1'b1};
  assign input_only       = '{out: 1'b0, oe: 1'b0};

  // Per-pin mode and port drive
  assign pin_mode[PIN_A11] = port_a_line11_function;
  assign pin_mode[PIN_B7]  = port_b_line7_function;
  assign pin_mode[PIN_C13] = port_c_line13_function;
  assign pin_port[PIN_A11] = i_port_a11;
  assign pin_port[PIN_B7]  = i_port_b7;
  assign pin_port[PIN_C13] = i_port_c13;

  // Function tables; unlisted codes are masked off by the mux
  // lines 11, 7 and 13
  always_comb begin
    pin_fn                  = '0;
    pin_fn[PIN_A11][MD_PORT] = i_port_a11;
    pin_fn[PIN_A11][MD_BUS]  = bus_drive_a11;
    pin_fn[PIN_B7][MD_PORT]  = i_port_b7;
    pin_fn[PIN_B7][MD_BUS]   = bus_drive_b7_adr;
    pin_fn[PIN_B7][MD_BUS_REQ] = bus_drive_b7_req;
    pin_fn[PIN_B7][MD_IRQ]   = input_only;
    pin_fn[PIN_B7][MD_POE]   = i_output_disable_pin_four;
    pin_fn[PIN_B7][MD_TXD]   = serial_drive_b7;
    pin_fn[PIN_C13][MD_PORT] = i_port_c13;
    pin_fn[PIN_C13][MD_BUS]  = bus_drive_c13;
  end

  // One mux per pin, each on its own field
  // per-pin select
  for (genvar p = 0; p < PIN_N; p++) begin : g_pin
    pfs_pin_mux #(
      .LEGAL (PIN_LEGAL[p])
    ) u_mux (
      .i_mode (pin_mode[p]),
      .i_port (pin_port[p]),
      .i_fn   (pin_fn[p]),
      .o_pin  (pin_drive[p])
    );
  end

  assign o_port_a_line_eleven   = pin_drive[PIN_A11];
  assign o_port_b_line_seven    = pin_drive[PIN_B7];
  assign o_port_c_line_thirteen = pin_drive[PIN_C13];

  // Pin level to the interrupt and output-disable units; idle low
  // input routing
  assign o_external_interrupt_six =
    (port_b_line7_function == MD_IRQ) & i_port_b_line_seven_in;
  assign o_output_disable_pin_four_in =
    (port_b_line7_function == MD_POE) & i_port_b_line_seven_in;

  // Checks on the routing and the register file
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_reset_n);

  AST_RD_A: assert property (
    (i_rd && hit_a) |=> (o_rdata == $past(port_a_low_function_select_3))
  ) else $error("port A readback wrong");

  AST_RSV_ZERO: assert property (
    i_wr && hit_b
    |=> (port_b_low_function_select_2 == ($past(i_wdata) & MASK_PORT_B))
  ) else $error("reserved bits stored");

  AST_A11_PORT: assert property (
    (port_a_line11_function == MD_PORT) |-> (o_port_a_line_eleven == i_port_a11)
  ) else $error("A11 not port");

  AST_A11_BUS: assert property (
    (port_a_line11_function == MD_BUS)
    |-> (o_port_a_line_eleven.out == i_top_byte_strobe_mask_hold) && o_port_a_line_eleven.oe
  ) else $error("A11 not bus strobe");

  AST_RST_A: assert property (
    disable iff (1'b0)
    (!i_reset_n && i_rom_off_ext32)
    |=> (port_a_low_function_select_3 == RST_EXT_PORT_A)
  ) else $error("port A ext reset wrong");

  AST_RST_B: assert property (
    disable iff (1'b0)
    (!i_reset_n && !i_rom_off_ext)
    |=> (port_b_low_function_select_2 == RST_PORT_B)
  ) else $error("port B reset wrong");

  AST_B7_ADR: assert property (
    (port_b_line7_function == MD_BUS)
    |-> (o_port_b_line_seven.out == i_address_bit_nineteen_out) && o_port_b_line_seven.oe
  ) else $error("B7 not address 19");

  AST_B7_REQ: assert property (
    (port_b_line7_function == MD_BUS_REQ)
    |-> (o_port_b_line_seven.out == i_bus_request_out) && o_port_b_line_seven.oe
  ) else $error("B7 not bus request");

  AST_B7_IRQ: assert property (
    (port_b_line7_function == MD_IRQ)
    |-> !o_port_b_line_seven.oe && (o_external_interrupt_six == i_port_b_line_seven_in)
  ) else $error("B7 irq routing wrong");

  AST_B7_POE: assert property (
    (port_b_line7_function == MD_POE)
    |-> (o_port_b_line_seven == i_output_disable_pin_four)
        && (o_output_disable_pin_four_in == i_port_b_line_seven_in)
  ) else $error("B7 poe routing wrong");

  AST_B7_TXD: assert property (
    (port_b_line7_function == MD_TXD)
    |-> (o_port_b_line_seven.out == i_serial0_transmit_out) && o_port_b_line_seven.oe
  ) else $error("B7 not serial tx");

  AST_C13_BAD: assert property (
    (port_c_line13_function > MD_BUS) |-> (o_port_c_line_thirteen == i_port_c13)
  ) else $error("C13 prohibited not port");

  AST_WR_NEXT: assert property (
    (i_wr && hit_a)
    ##1 ($past(i_wdata[LSB_A11 +: MODE_W]) == MD_BUS)
    |-> (o_port_a_line_eleven.out == i_top_byte_strobe_mask_hold)
        && $stable(port_b_low_function_select_2)
  ) else $error("write not applied next cycle");

  AST_RD_B: assert property (
    (i_rd && hit_b)
    |=> (o_rdata == $past(port_b_low_function_select_2))
  ) else $error("port B readback wrong");

  AST_RD_IDLE: assert property (
    !i_rd |=> (o_rdata == '0)
  ) else $error("read data without a read");

  AST_A11_BAD: assert property (
    (port_a_line11_function > MD_BUS) |-> (o_port_a_line_eleven == i_port_a11)
  ) else $error("A11 prohibited not port");

  AST_B7_PORT: assert property (
    (port_b_line7_function == MD_PORT) |-> (o_port_b_line_seven == i_port_b7)
  ) else $error("B7 not port");

  AST_B7_BAD: assert property (
    (port_b_line7_function > MD_TXD) |-> (o_port_b_line_seven == i_port_b7)
  ) else $error("B7 prohibited not port");

  AST_C13_BUS: assert property (
    (port_c_line13_function == MD_BUS)
    |-> (o_port_c_line_thirteen.out == i_address_bit_thirteen_out) && o_port_c_line_thirteen.oe
  ) else $error("C13 not address out");

  AST_C13_PORT: assert property (
    (port_c_line13_function == MD_PORT) |-> (o_port_c_line_thirteen == i_port_c13)
  ) else $error("C13 not port");

  AST_IRQ_IDLE: assert property (
    (port_b_line7_function != MD_IRQ) |-> !o_external_interrupt_six
  ) else $error("interrupt input not idle");

  AST_RST_C: assert property (
    disable iff (1'b0)
    (!i_reset_n && i_rom_off_ext)
    |=> (port_c_function_select == RST_EXT_PORT_C)
  ) else $error("port C ext reset wrong");

endmodule

`default_nettype wire

// File: pfs_pkg.sv
`default_nettype none

package pfs_pkg;

  // Register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int MODE_W = 3;
  localparam int CODE_N = 8;

  // Byte offsets of the function select registers
  localparam logic [ADDR_W-1:0] OFS_PORT_A = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_PORT_B = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_PORT_C = 8'h08;

  // Writable bits; every other bit is reserved and reads zero
  localparam logic [DATA_W-1:0] MASK_PORT_A = 16'h7777;
  localparam logic [DATA_W-1:0] MASK_PORT_B = 16'h7700;
  localparam logic [DATA_W-1:0] MASK_PORT_C = 16'h0070;

  // Reset values: normal boot and ROM-disabled external boot
  localparam logic [DATA_W-1:0] RST_PORT_A     = 16'h0000;
  localparam logic [DATA_W-1:0] RST_PORT_B     = 16'h0000;
  localparam logic [DATA_W-1:0] RST_PORT_C     = 16'h0000;
  localparam logic [DATA_W-1:0] RST_EXT_PORT_A = 16'h1111;
  localparam logic [DATA_W-1:0] RST_EXT_PORT_B = 16'h1100;
  localparam logic [DATA_W-1:0] RST_EXT_PORT_C = 16'h0010;

  // Field positions of the three muxed pins
  localparam int LSB_A11 = 12;
  localparam int LSB_B7  = 12;
  localparam int LSB_C13 = 4;

  // Mode codes
  localparam logic [MODE_W-1:0] MD_PORT    = 3'h0;
  localparam logic [MODE_W-1:0] MD_BUS     = 3'h1;
  localparam logic [MODE_W-1:0] MD_BUS_REQ = 3'h2;
  localparam logic [MODE_W-1:0] MD_IRQ     = 3'h3;
  localparam logic [MODE_W-1:0] MD_POE     = 3'h4;
  localparam logic [MODE_W-1:0] MD_TXD     = 3'h5;

  // Pin indices and legal code sets, one bit per code
  localparam int PIN_A11 = 0;
  localparam int PIN_B7  = 1;
  localparam int PIN_C13 = 2;
  localparam int PIN_N   = 3;
  localparam logic [CODE_N-1:0] LEGAL_A11 = 8'h03;
  localparam logic [CODE_N-1:0] LEGAL_B7  = 8'h3f;
  localparam logic [CODE_N-1:0] LEGAL_C13 = 8'h03;

  typedef logic [MODE_W-1:0] pfs_mode_t;

  // Drive of one pin: level and output enable
  typedef struct packed {
    logic out;
    logic oe;
  } pfs_pin_s;

endpackage

`default_nettype wire

// File: pfs_pin_mux.sv
`default_nettype none

module pfs_pin_mux #(
  parameter logic [7:0] LEGAL = 8'h03
) (
  input  wire pfs_pkg::pfs_mode_t      i_mode, // Mode field
  input  wire pfs_pkg::pfs_pin_s       i_port, // Port drive
  input  wire pfs_pkg::pfs_pin_s [7:0] i_fn,   // Drive per code
  output wire pfs_pkg::pfs_pin_s       o_pin   // Pin drive
);
  import pfs_pkg::*;

  wire code_legal;

  // Prohibited codes fall back to port so the pin never floats oddly
  assign code_legal = LEGAL[i_mode];
  assign o_pin      = code_legal ? i_fn[i_mode] : i_port;

endmodule

`default_nettype wire

// File: pfs_far_model.sv
`default_nettype none

// Far side: port controller, bus controller, serial, output-disable unit and the B7 wire
module pfs_far_model (
  input  wire logic              i_clock,    // Shared clock
  input  wire pfs_pkg::pfs_pin_s i_b7_drive, // Design drive on B7
  output wire pfs_pkg::pfs_pin_s o_port_a11, // Port drive A11
  output wire pfs_pkg::pfs_pin_s o_port_b7,  // Port drive B7
  output wire pfs_pkg::pfs_pin_s o_port_c13, // Port drive C13
  output wire logic              o_top_s,    // Strobe/mask/hold
  output wire logic              o_addr19,   // Address bit 19
  output wire logic              o_bus_req,  // Bus request
  output wire logic              o_addr13,   // Address bit 13
  output wire pfs_pkg::pfs_pin_s o_poe,      // Output-disable drive
  output wire logic              o_txd,      // Serial transmit
  output wire logic              o_b7_level  // Resolved B7 wire
);
  timeunit 1ns;
  timeprecision 1ns;
  import pfs_pkg::*;

  logic [7:0] cnt = 8'h00;

  // Sources follow counter bits; only o_top_s, o_addr19 and o_port_a11 change every cycle
  always @(posedge i_clock) begin
    cnt <= cnt + 8'h01;
  end

  assign o_port_a11 = cnt[1:0];
  assign o_port_b7  = cnt[2:1];
  assign o_port_c13 = cnt[3:2];
  assign o_top_s    = cnt[0];
  assign o_addr19   = ~cnt[0];
  assign o_bus_req  = cnt[1];
  assign o_addr13   = ~cnt[1];
  assign o_poe      = cnt[4:3];
  assign o_txd      = cnt[2] ^ cnt[5];
  // Undriven wire follows an outside level that changes on 63 of every 64 cycles
  assign o_b7_level = i_b7_drive.oe ? i_b7_drive.out : (cnt[6] ^ cnt[0]);
endmodule

`default_nettype wire

// File: tb_top.sv
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin mismatches++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import pfs_pkg::*;

  typedef struct {int pin; int code; int src;} pfs_row_s;

  logic                i_clock = 1'b0;
  logic                i_reset_n = 1'b0;
  logic                strap32 = 1'b0;
  logic                strap = 1'b0;
  logic                bus_wr = 1'b0;
  logic                bus_rd = 1'b0;
  logic [ADDR_W-1:0]   addr = '0;
  logic [DATA_W-1:0]   wdata = '0;
  logic [DATA_W-1:0]   rv;
  logic [1:0]          got;
  wire  [DATA_W-1:0]   rdata;
  wire  pfs_pin_s      port_a11, port_b7, port_c13, poe_drv, a11, b7, c13;
  wire                 top_s, addr19, bus_req, addr13, txd, b7_lvl, int_six, poe_in;
  int                  mismatches = 0;
  int                  checked = 0;
  int                  p;
  logic [ADDR_W-1:0]   ofs_of [3] = '{OFS_PORT_A, OFS_PORT_B, OFS_PORT_C};
  int                  lsb_of [3] = '{LSB_A11, LSB_B7, LSB_C13};
  logic [DATA_W-1:0]   mask_of [3] = '{MASK_PORT_A, MASK_PORT_B, MASK_PORT_C};
  // Pin, code written, function expected (3 = input only)
  pfs_row_s rows [24] = '{
    '{0,0,0}, '{0,1,1}, '{0,2,0}, '{0,3,0}, '{0,4,0}, '{0,5,0}, '{0,6,0}, '{0,7,0},
    '{1,0,0}, '{1,1,1}, '{1,2,2}, '{1,3,3}, '{1,4,4}, '{1,5,5}, '{1,6,0}, '{1,7,0},
    '{2,0,0}, '{2,1,1}, '{2,2,0}, '{2,3,0}, '{2,4,0}, '{2,5,0}, '{2,6,0}, '{2,7,0}};

  always #25 i_clock = ~i_clock;

  pfs_top i_pfs_top (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_rom_off_ext32(strap32),
    .i_rom_off_ext(strap), .i_addr(addr), .i_wdata(wdata), .i_wr(bus_wr), .i_rd(bus_rd),
    .o_rdata(rdata), .i_port_a11(port_a11), .i_port_b7(port_b7), .i_port_c13(port_c13),
    .i_top_byte_strobe_mask_hold(top_s), .i_address_bit_nineteen_out(addr19),
    .i_bus_request_out(bus_req), .i_address_bit_thirteen_out(addr13),
    .i_output_disable_pin_four(poe_drv), .i_serial0_transmit_out(txd),
    .i_port_b_line_seven_in(b7_lvl), .o_port_a_line_eleven(a11), .o_port_b_line_seven(b7),
    .o_port_c_line_thirteen(c13), .o_external_interrupt_six(int_six),
    .o_output_disable_pin_four_in(poe_in));

  pfs_far_model i_pfs_far_model (.i_clock(i_clock), .i_b7_drive(b7), .o_port_a11(port_a11),
    .o_port_b7(port_b7), .o_port_c13(port_c13), .o_top_s(top_s), .o_addr19(addr19),
    .o_bus_req(bus_req), .o_addr13(addr13), .o_poe(poe_drv), .o_txd(txd), .o_b7_level(b7_lvl));

  // Drive a pin should show for a selected function
  function automatic logic [1:0] exp_pin(int pn, int s);
    case (s)
      1: exp_pin = {(pn == 0) ? top_s : (pn == 1) ? addr19 : addr13, 1'b1};
      2: exp_pin = {bus_req, 1'b1};
      4: exp_pin = poe_drv;
      5: exp_pin = {txd, 1'b1};
      default: exp_pin = (pn == 0) ? port_a11 : (pn == 1) ? port_b7 : port_c13;
    endcase
  endfunction

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_clock);
    bus_wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge i_clock);
    bus_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge i_clock);
    bus_rd <= 1'b1;
    addr <= a;
    @(posedge i_clock);
    bus_rd <= 1'b0;
    @(negedge i_clock);
    d = rdata;
  endtask

  task automatic do_reset(input logic e32, input logic e);
    @(posedge i_clock);
    i_reset_n <= 1'b0;
    strap32 <= e32;
    strap <= e;
    repeat (20) @(posedge i_clock);
    i_reset_n <= 1'b1;
    @(negedge i_clock);
    `CHK(a11, exp_pin(0, e32 ? 1 : 0))
    `CHK(b7, exp_pin(1, e ? 1 : 0))
    `CHK(c13, exp_pin(2, e ? 1 : 0))
    rd(OFS_PORT_A, rv);
    `CHK(rv, e32 ? RST_EXT_PORT_A : RST_PORT_A)
    rd(OFS_PORT_B, rv);
    `CHK(rv, e ? RST_EXT_PORT_B : RST_PORT_B)
    rd(OFS_PORT_C, rv);
    `CHK(rv, e ? RST_EXT_PORT_C : RST_PORT_C)
    $display("test reset done");
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Watchdog against a hung sequence
  initial begin
    repeat (5000) @(posedge i_clock);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    do_reset(1'b0, 1'b0);
    // Every code on every pin, checked over two cycles of changing sources
    foreach (rows[k]) begin
      p = rows[k].pin;
      wr(ofs_of[p], DATA_W'(rows[k].code) << lsb_of[p]);
      repeat (2) begin
        @(negedge i_clock);
        got = (p == 0) ? a11 : (p == 1) ? b7 : c13;
        if (rows[k].src == 3) `CHK(got[0], 1'b0)
        else `CHK(got, exp_pin(p, rows[k].src))
        `CHK(int_six, (p == 1 && rows[k].code == 3) ? b7_lvl : 1'b0)
        `CHK(poe_in, (p == 1 && rows[k].code == 4) ? b7_lvl : 1'b0)
      end
      rd(ofs_of[p], rv);
      `CHK(rv, DATA_W'(rows[k].code) << lsb_of[p])
    end
    $display("test table done");
    // Every field bit set; software keeps reserved bits zero, so they must read zero
    foreach (ofs_of[i]) begin
      wr(ofs_of[i], mask_of[i]);
      rd(ofs_of[i], rv);
      `CHK(rv, mask_of[i])
    end
    `CHK(b7, exp_pin(1, 0))
    wr(8'h0c, 16'h7777);
    rd(8'h0c, rv);
    `CHK(rv, 16'h0000)
    $display("test reserved done");
    // Switch exactly one cycle after the write edge, read straight behind it
    wr(OFS_PORT_B, 16'h0000);
    @(posedge i_clock);
    bus_wr <= 1'b1;
    wdata <= 16'h5000;
    @(negedge i_clock);
    `CHK(b7, exp_pin(1, 0))
    @(posedge i_clock);
    bus_wr <= 1'b0;
    bus_rd <= 1'b1;
    @(negedge i_clock);
    `CHK(b7, exp_pin(1, 5))
    `CHK(a11, exp_pin(0, 0))
    @(posedge i_clock);
    bus_rd <= 1'b0;
    @(negedge i_clock);
    `CHK(rdata, 16'h5000)
    @(negedge i_clock);
    `CHK(rdata, 16'h0000)
    $display("test timing done");
    do_reset(1'b1, 1'b1);
    tally_and_finish();
  end
endmodule

`default_nettype wire
